//--- core/ehf_pkg.sv
// Shared constants and types for the external host flash programming port.
package ehf_pkg;

  // Clock period and derived cycle counts (least times round up).
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ARM_HOLD_NS   = 1000000;
  localparam int ERASE_TIME_NS = 10000;
  localparam int PROG_TIME_NS  = 400;
  localparam int ARM_HOLD_CYC  =
    (ARM_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ERASE_CYC     =
    (ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROG_CYC      =
    (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMER_W       = 16;

  // Command codes as {control_port[7:6], high_addr_port[7:6]}.
  localparam logic [3:0] CMD_IDENTIFY    = 4'h0;
  localparam logic [3:0] CMD_CHIP_ERASE  = 4'h1;
  localparam logic [3:0] CMD_BANK_ERASE  = 4'hd;
  localparam logic [3:0] CMD_PAGE_ERASE  = 4'hb;
  localparam logic [3:0] CMD_BYTE_WRITE  = 4'he;
  localparam logic [3:0] CMD_ROW_WRITE   = 4'h6;
  localparam logic [3:0] CMD_VERIFY      = 4'hc;
  localparam logic [3:0] CMD_LOCK_A      = 4'hf;
  localparam logic [3:0] CMD_LOCK_B      = 4'h3;
  localparam logic [3:0] CMD_LOCK_C      = 4'h5;
  localparam logic [3:0] CMD_MAP_LOW     = 4'h8;
  localparam logic [3:0] CMD_MAP_HIGH    = 4'h9;

  // Identify byte addresses on the low address port.
  localparam logic [7:0] ID_MAKER_ADDR  = 8'h30;
  localparam logic [7:0] ID_DEVICE_ADDR = 8'h31;

  // Bank and page decoding of the 16-bit flash address.
  localparam logic [15:0] BANK0_MASK  = 16'h8000;
  localparam logic [15:0] BANK0_MATCH = 16'h0000;
  localparam logic [15:0] BANK1_MASK  = 16'hf000;
  localparam logic [15:0] BANK1_MATCH = 16'hf000;
  localparam logic [15:0] PAGE0_MASK  = 16'hff80;
  localparam logic [15:0] PAGE1_MASK  = 16'hffc0;
  localparam logic [15:0] ALL_MASK    = 16'h0000;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [7:0]  EMPTY_BYTE  = 8'h00;

  // Pin group as it arrives at the device.
  typedef struct packed {
    logic       rst;
    logic       entry_n;
    logic       strobe_n;
    logic       ea_n;
    logic [7:0] data;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [3:0] ctl;
  } ehf_pins_t;

  // One flash array operation, issued as a single-cycle request.
  typedef struct packed {
    logic        erase;
    logic        write;
    logic [15:0] addr;
    logic [15:0] mask;
    logic [7:0]  data;
  } ehf_flash_req_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_BUSY   = 3'b010,
    ST_COMMIT = 3'b100
  } ehf_state_t;

endpackage

//--- core/ehf_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module ehf_sync
  import ehf_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) $error("ehf_sync width must be at least one");
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

//--- core/ehf_flash_array.sv
// Flash byte array with erase-to-ones and bit-clearing writes.
`timescale 1ns/1ps
module ehf_flash_array
  import ehf_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Operation request
  input  wire ehf_flash_req_t    req,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0] mem [0:DEPTH-1];

  initial begin
    if (ADDR_W < 8 || ADDR_W > 16) $error("ehf_flash_array ADDR_W 8..16");
  end

  // Programming can only clear bits; an erase is needed to set them back.
  always_ff @(posedge core_clk) begin
    if (req.erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        if ((ADDR_W'(i) & req.mask[ADDR_W-1:0]) ==
            (req.addr[ADDR_W-1:0] & req.mask[ADDR_W-1:0])) begin
          mem[i] <= ERASED_BYTE;
        end
      end
    end else if (req.write) begin
      mem[req.addr[ADDR_W-1:0]] <= mem[req.addr[ADDR_W-1:0]] & req.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data <= ERASED_BYTE;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

//--- core/ehf_host_port.sv
// Host programming port: mode entry, arming, command decode and sequencing.
//
// How it works
// - Mode entered by entry pin falling with reset high; held while both.
// - Only identify is honoured until the device has been armed.
// - Data port is write input and read output for read commands.
// - Low address port carries flash address bits 7..0 directly.
// - Address 13..8 from high port, 15 and 14 from control port 5, 4.
// - Command code is control port 7,6 with high port 7,6.
// - Control port bit 3 shows ready or busy during operations.
// - Erase, write and lock timing is generated by internal counters.
// - Twelve commands are decoded from the control pins.
// - Mode starts on entry falling edge; commands on strobe falling edge.
// - A command needs reset high, entry low and external access high.
// - Verify reads the addressed flash byte, or all ones in a locked bank, with strobe high.
// - Whole-array erase ignores address and data.
// - Bank erase picks the bank from address bits 15..12.
// - Page erase selects the page from address bits 15..7, or 15..6 in the top bank.
// - Byte write stores the data port at the addressed location.
// - Row write takes data and full address, one byte per strobe.
// - Three lock-bit writes ignore address and data.
// - Two map-default bit writes ignore address and data.
// - Bank or page erase and writes to a locked bank are ignored; whole erase clears locks.
// - Every erase leaves affected bytes at all ones.
// - In mode, core is held in reset and the oscillator runs.
`timescale 1ns/1ps
module ehf_host_port
  import ehf_pkg::*;
#(
  parameter int         ARM_CYCLES  = ARM_HOLD_CYC,
  parameter int         ADDR_W      = 16,
  // Identification bytes; values are arbitrary.
  parameter logic [7:0] MAKER_CODE  = 8'h5a,
  parameter logic [7:0] DEVICE_CODE = 8'h3c
) (
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      srst,
  // Host pins
  input  wire ehf_pins_t pins_i,
  output logic     [7:0] data_port_o,
  output logic           data_port_oe,
  output logic           ready_busy_o,
  output logic           ready_busy_oe,
  // Device control
  output logic           core_hold_rst,
  output logic           osc_enable,
  // Status
  output logic           prog_mode,
  output logic           armed,
  output logic     [2:0] lock_bits,
  output logic     [1:0] map_default
);

  localparam int ARM_W = $clog2(ARM_CYCLES + 1);

  initial begin
    if (ARM_CYCLES < 1) $error("ARM_CYCLES must be at least one");
    if (ERASE_CYC >= (1 << TIMER_W) || PROG_CYC < 1) begin
      $error("operation timing does not fit the timer");
    end
  end

  // Synchronised pins and edge history.
  ehf_pins_t      pins_s;
  logic           entry_n_d_reg;
  logic           strobe_n_d_reg;
  // Mode, arming and sequencing state.
  logic           mode_reg;
  logic           armed_reg;
  logic [ARM_W-1:0] arm_cnt_reg;
  ehf_state_t     state_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [3:0]     op_code_reg;
  logic [15:0]    op_addr_reg;
  logic [7:0]     op_data_reg;
  logic [2:0]     lock_reg;
  logic [1:0]     map_reg;
  logic           ready_reg;
  ehf_flash_req_t req_reg;
  // Read path.
  logic [7:0]     rd_data;
  logic [7:0]     data_out_reg;
  logic           data_oe_reg;
  logic           oe_d_reg;
  // Decode.
  logic [3:0]     code;
  logic [15:0]    addr;
  logic           cmd_ok;
  logic           strobe_fall;
  logic           strobed_cmd;
  logic           bank0_hit;
  logic           bank1_hit;
  logic           lock_hit;
  logic           accept;
  logic [TIMER_W-1:0] op_cycles;

  // The synchroniser clears to zero, so a host already holding the entry pin
  // low when reset lifts shows no falling edge and cannot slip into the mode.
  ehf_sync #(
    .W ($bits(ehf_pins_t))
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .d        (pins_i),
    .q        (pins_s)
  );

  ehf_flash_array #(
    .ADDR_W (ADDR_W)
  ) u_array (
    .core_clk (core_clk),
    .srst     (srst),
    .req      (req_reg),
    .rd_addr  (addr[ADDR_W-1:0]),
    .rd_data  (rd_data)
  );

  assign code = {pins_s.ctl[3:2], pins_s.hi[7:6]};
  assign addr = {pins_s.ctl[1:0], pins_s.hi[5:0], pins_s.lo};

  // Qualifying levels must all hold for any command to count.
  assign cmd_ok = mode_reg && pins_s.rst && !pins_s.entry_n
                  && pins_s.ea_n;
  assign strobe_fall = strobe_n_d_reg && !pins_s.strobe_n;

  // A bank that is neither the low half nor the top 4K block matches none.
  assign bank0_hit = (addr & BANK0_MASK) == BANK0_MATCH;
  assign bank1_hit = (addr & BANK1_MASK) == BANK1_MATCH;
  assign lock_hit  = (bank0_hit && (lock_reg[0] || lock_reg[2]))
                     || (bank1_hit && (lock_reg[1] || lock_reg[2]));

  always_comb begin
    strobed_cmd = 1'b0;
    op_cycles   = TIMER_W'(PROG_CYC);
    case (code)
      CMD_CHIP_ERASE: begin
        strobed_cmd = 1'b1;
        op_cycles   = TIMER_W'(ERASE_CYC);
      end
      CMD_BANK_ERASE, CMD_PAGE_ERASE: begin
        strobed_cmd = (bank0_hit || bank1_hit) && !lock_hit;
        op_cycles   = TIMER_W'(ERASE_CYC);
      end
      CMD_BYTE_WRITE, CMD_ROW_WRITE: begin
        strobed_cmd = (bank0_hit || bank1_hit) && !lock_hit;
      end
      CMD_LOCK_A, CMD_LOCK_B, CMD_LOCK_C,
      CMD_MAP_LOW, CMD_MAP_HIGH: begin
        strobed_cmd = 1'b1;
      end
      default: begin
        strobed_cmd = 1'b0;
      end
    endcase
  end

  // Identify never starts a sequence, and accept needs armed_reg, so an unarmed device stays idle.
  // A strobe that falls while busy is lost, not queued; wait for ready.
  assign accept = strobe_fall && cmd_ok && armed_reg
                  && (state_reg == ST_IDLE) && strobed_cmd;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      entry_n_d_reg  <= 1'b1;
      strobe_n_d_reg <= 1'b1;
    end else begin
      entry_n_d_reg  <= pins_s.entry_n;
      strobe_n_d_reg <= pins_s.strobe_n;
    end
  end

  // Mode entry needs a real high-to-low edge, not a pin already low.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= 1'b0;
    end else if (!pins_s.rst || pins_s.entry_n) begin
      mode_reg <= 1'b0;
    end else if (entry_n_d_reg) begin
      mode_reg <= 1'b1;
    end
  end

  // Arming counts cycles of an unbroken identify; any break restarts it.
  always_ff @(posedge core_clk) begin
    if (srst || !mode_reg) begin
      armed_reg   <= 1'b0;
      arm_cnt_reg <= '0;
    end else if (cmd_ok && pins_s.strobe_n && code == CMD_IDENTIFY) begin
      if (arm_cnt_reg >= ARM_W'(ARM_CYCLES - 1)) begin
        armed_reg <= 1'b1;
      end else begin
        arm_cnt_reg <= arm_cnt_reg + 1'b1;
      end
    end else begin
      arm_cnt_reg <= '0;
    end
  end

  // Sequencer: the operation is committed only when its own time is up.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg   <= ST_IDLE;
      timer_reg   <= '0;
      op_code_reg <= CMD_IDENTIFY;
      op_addr_reg <= '0;
      op_data_reg <= ERASED_BYTE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg   <= ST_BUSY;
            timer_reg   <= op_cycles - 1'b1;
            op_code_reg <= code;
            op_addr_reg <= addr;
            op_data_reg <= pins_s.data;
          end
        end
        ST_BUSY: begin
          if (timer_reg == '0) begin
            state_reg <= ST_COMMIT;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        ST_COMMIT: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    req_reg <= '0;
    if (!srst && state_reg == ST_COMMIT) begin
      req_reg.addr <= op_addr_reg;
      req_reg.data <= op_data_reg;
      case (op_code_reg)
        CMD_CHIP_ERASE: begin
          req_reg.erase <= 1'b1;
          req_reg.mask  <= ALL_MASK;
        end
        CMD_BANK_ERASE: begin
          req_reg.erase <= 1'b1;
          req_reg.mask  <= op_addr_reg[15] ? BANK1_MASK : BANK0_MASK;
        end
        CMD_PAGE_ERASE: begin
          req_reg.erase <= 1'b1;
          req_reg.mask  <= op_addr_reg[15] ? PAGE1_MASK : PAGE0_MASK;
        end
        CMD_BYTE_WRITE, CMD_ROW_WRITE: begin
          req_reg.write <= 1'b1;
        end
        default: begin
          req_reg.erase <= 1'b0;
        end
      endcase
    end
  end

  // Lock and map bits are set by their own commands, cleared by chip erase.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_reg <= '0;
      map_reg  <= '0;
    end else if (state_reg == ST_COMMIT) begin
      case (op_code_reg)
        CMD_CHIP_ERASE: begin
          lock_reg <= '0;
          map_reg  <= '0;
        end
        CMD_LOCK_A:   lock_reg[0] <= 1'b1;
        CMD_LOCK_B:   lock_reg[1] <= 1'b1;
        CMD_LOCK_C:   lock_reg[2] <= 1'b1;
        CMD_MAP_LOW:  map_reg[0]  <= 1'b1;
        CMD_MAP_HIGH: map_reg[1]  <= 1'b1;
        default: begin
          lock_reg <= lock_reg;
        end
      endcase
    end
  end

  // Busy from the edge after acceptance until the commit has been issued.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ready_reg <= 1'b1;
    end else if (accept) begin
      ready_reg <= 1'b0;
    end else if (state_reg == ST_COMMIT) begin
      ready_reg <= 1'b1;
    end
  end

  // Reads are level driven: they follow the pins while the strobe is high.
  // Gating the enable with both stages lets go of the port one cycle before
  // the data register would, which shortens the host's bus turnaround.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_oe_reg  <= 1'b0;
      oe_d_reg     <= 1'b0;
      data_out_reg <= EMPTY_BYTE;
    end else begin
      oe_d_reg    <= cmd_ok && pins_s.strobe_n
                     && (code == CMD_IDENTIFY
                         || (code == CMD_VERIFY && armed_reg));
      data_oe_reg <= oe_d_reg;
      if (code == CMD_IDENTIFY) begin
        if (pins_s.lo == ID_MAKER_ADDR) begin
          data_out_reg <= MAKER_CODE;
        end else if (pins_s.lo == ID_DEVICE_ADDR) begin
          data_out_reg <= DEVICE_CODE;
        end else begin
          data_out_reg <= EMPTY_BYTE;
        end
      end else if (lock_hit) begin
        data_out_reg <= ERASED_BYTE;
      end else begin
        data_out_reg <= rd_data;
      end
    end
  end

  assign data_port_o   = data_out_reg;
  assign data_port_oe  = data_oe_reg && oe_d_reg;
  assign ready_busy_o  = ready_reg;
  assign ready_busy_oe = mode_reg;
  assign core_hold_rst = mode_reg;
  assign osc_enable    = mode_reg;
  assign prog_mode     = mode_reg;
  assign armed         = armed_reg;
  assign lock_bits     = lock_reg;
  assign map_default   = map_reg;

endmodule

//--- sim/ehf_chk.sv
// Concurrent checks on the host programming port outputs.
`timescale 1ns/1ps
module ehf_chk
  import ehf_pkg::*;
#(
  parameter int ARM_CYCLES = 16
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // Host side
  input wire ehf_pins_t  pins_i,
  input wire logic [7:0] data_port_o,
  input wire logic       data_port_oe,
  input wire logic       ready_busy_o,
  input wire logic       ready_busy_oe,
  // Status
  input wire logic       core_hold_rst,
  input wire logic       osc_enable,
  input wire logic       prog_mode,
  input wire logic       armed,
  input wire logic [2:0] lock_bits,
  input wire logic [1:0] map_default
);
  localparam int ARM_MIN = ARM_CYCLES;
  int mode_cnt;
  int busy_cnt;

  // Busy cycles so far; no operation may outlast an erase and its commit.
  always_ff @(posedge core_clk) begin
    if (srst || ready_busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  // Cycles spent in the mode, saturating once arming could be complete.
  always_ff @(posedge core_clk) begin
    if (srst || !prog_mode) begin
      mode_cnt <= 0;
    end else if (mode_cnt < ARM_CYCLES) begin
      mode_cnt <= mode_cnt + 1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_mode_outputs:
    assert property (prog_mode |-> core_hold_rst && osc_enable && ready_busy_oe)
    else $error("mode outputs not all active");
  chk_mode_pins:
    assert property (prog_mode |->
      $past(pins_i.rst, 3) && !$past(pins_i.entry_n, 3))
    else $error("mode held without reset high and entry low");
  chk_entry_edge:
    assert property ($rose(prog_mode) |-> $past(pins_i.entry_n, 4))
    else $error("mode entered without entry falling edge");
  chk_arm_clear:
    assert property (!prog_mode |=> !armed)
    else $error("armed outside programming mode");
  chk_arm_time:
    assert property ($rose(armed) |-> mode_cnt >= ARM_MIN)
    else $error("armed too soon after mode entry");
  chk_accept_cause:
    assert property ($fell(ready_busy_o) |-> armed && $past(pins_i.ea_n, 3)
      && !$past(pins_i.strobe_n, 3) && $past(pins_i.strobe_n, 4))
    else $error("busy without a qualified strobe fall");
  chk_busy_min:
    assert property ($fell(ready_busy_o) |-> !ready_busy_o [*8])
    else $error("busy ended too early");
  chk_busy_max:
    assert property (!ready_busy_o |-> busy_cnt <= ERASE_CYC + 1)
    else $error("busy did not end in time");
  chk_lock_commit:
    assert property ($changed({lock_bits, map_default}) |->
      $rose(ready_busy_o))
    else $error("lock or map bits changed outside a commit");
  chk_read_strobe:
    assert property (data_port_oe |-> prog_mode && $past(pins_i.strobe_n, 4))
    else $error("data port driven outside a read");

  cov_busy:  cover property ($fell(ready_busy_o));
  cov_armed: cover property ($rose(armed));
  cov_read:  cover property ($rose(data_port_oe));
endmodule

bind ehf_host_port ehf_chk #(.ARM_CYCLES(ARM_CYCLES)) u_chk (
  .core_clk(core_clk), .srst(srst), .pins_i(pins_i),
  .data_port_o(data_port_o), .data_port_oe(data_port_oe),
  .ready_busy_o(ready_busy_o), .ready_busy_oe(ready_busy_oe),
  .core_hold_rst(core_hold_rst), .osc_enable(osc_enable),
  .prog_mode(prog_mode), .armed(armed), .lock_bits(lock_bits),
  .map_default(map_default)
);

//--- sim/ehf_host_model.sv
// External programmer pins with the shared data bus resolved.
`timescale 1ns/1ps
module ehf_host_model
  import ehf_pkg::*;
(
  input wire logic       core_clk,
  input wire ehf_pins_t  req,
  input wire logic       drive,
  input wire logic [7:0] dev_data,
  input wire logic       dev_oe,
  output ehf_pins_t      pins
);
  logic [7:0] last = 8'h00;

  always_ff @(posedge core_clk) begin
    last <= pins.data;
  end

  // A released bus toggles so that a stale byte never reads as valid.
  always_comb begin
    pins = req;
    if (dev_oe) begin
      pins.data = dev_data;
    end else if (!drive) begin
      pins.data = ~last;
    end
  end
endmodule

//--- sim/ehf_host_port_tb.sv
// Self-checking bench for the host programming port.
`timescale 1ns/1ps
module ehf_host_port_tb;
  import ehf_pkg::*;
  typedef struct packed {
    logic        strobed;
    logic [3:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  exp;
  } ehf_row_t;
  localparam int ARM = 16;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic       drive = 1'b0;
  ehf_pins_t  req = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, 4'h0};
  ehf_pins_t  pins;
  logic [7:0] dq_o;
  logic       dq_oe, rdy, rdy_oe, hold, osc, mode, armed;
  logic [2:0] locks;
  logic [1:0] mapd;
  int         err_total = 0;
  int         samples_checked = 0;
  // Reads expect a byte; strobes expect 01 if accepted, 00 if refused.
  ehf_row_t   rows [20] = '{
    '{1'b0, CMD_IDENTIFY, 16'h0030, 8'h00, 8'h5a},
    '{1'b0, CMD_IDENTIFY, 16'h0031, 8'h00, 8'h3c},
    '{1'b0, CMD_IDENTIFY, 16'h0032, 8'h00, 8'h00},
    '{1'b1, CMD_CHIP_ERASE, 16'h0000, 8'h00, 8'h01},
    '{1'b0, CMD_VERIFY, 16'h1234, 8'h00, 8'hff},
    '{1'b1, CMD_BYTE_WRITE, 16'h1234, 8'ha5, 8'h01},
    '{1'b1, CMD_ROW_WRITE, 16'h1235, 8'h3c, 8'h01},
    '{1'b0, CMD_VERIFY, 16'h1234, 8'h00, 8'ha5},
    '{1'b0, CMD_VERIFY, 16'h1235, 8'h00, 8'h3c},
    '{1'b1, CMD_PAGE_ERASE, 16'h1200, 8'h00, 8'h01},
    '{1'b0, CMD_VERIFY, 16'h1235, 8'h00, 8'hff},
    '{1'b1, CMD_BYTE_WRITE, 16'hf421, 8'h0f, 8'h01},
    '{1'b0, CMD_VERIFY, 16'hf421, 8'h00, 8'h0f},
    '{1'b1, CMD_BANK_ERASE, 16'hf000, 8'h00, 8'h01},
    '{1'b0, CMD_VERIFY, 16'hf421, 8'h00, 8'hff},
    '{1'b1, CMD_MAP_LOW, 16'h0000, 8'h00, 8'h01},
    '{1'b1, CMD_MAP_HIGH, 16'h0000, 8'h00, 8'h01},
    '{1'b1, CMD_LOCK_A, 16'h0000, 8'h00, 8'h01},
    '{1'b1, CMD_BYTE_WRITE, 16'h0010, 8'h00, 8'h00},
    '{1'b1, CMD_LOCK_B, 16'h0000, 8'h00, 8'h01}
  };

  ehf_host_model HOST (
    .core_clk(core_clk), .req(req), .drive(drive),
    .dev_data(dq_o), .dev_oe(dq_oe), .pins(pins)
  );

  ehf_host_port #(.ARM_CYCLES(ARM)) DUT (
    .core_clk(core_clk), .srst(srst), .pins_i(pins),
    .data_port_o(dq_o), .data_port_oe(dq_oe), .ready_busy_o(rdy),
    .ready_busy_oe(rdy_oe), .core_hold_rst(hold), .osc_enable(osc),
    .prog_mode(mode), .armed(armed), .lock_bits(locks),
    .map_default(mapd)
  );

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [3:0] c, input logic [15:0] a,
                     input logic [7:0] d, input logic drv);
    @(negedge core_clk);
    req.ctl = {c[3:2], a[15:14]};
    req.hi = {c[1:0], a[13:8]};
    req.lo = a[7:0];
    req.data = d;
    drive = drv;
  endtask

  task automatic rd(input logic [3:0] c, input logic [15:0] a,
                    input logic [7:0] exp);
    put(c, a, 8'h00, 1'b0);
    repeat (6) @(negedge core_clk);
    cmp8({7'h00, dq_oe}, 8'h01);
    cmp8(pins.data, exp);
  endtask

  // Holds the strobe long enough to see busy; again restrikes mid-busy.
  task automatic strobe(input logic [3:0] c, input logic [15:0] a,
                        input logic [7:0] d, input logic [7:0] exp,
                        input logic again);
    int n;
    logic [7:0] seen;
    seen = 8'h00;
    put(c, a, d, 1'b1);
    // A read may still own the data port for three edges; wait it out.
    repeat (6) @(negedge core_clk);
    req.strobe_n = 1'b0;
    for (n = 0; n < 8; n++) begin
      @(negedge core_clk);
      if (rdy === 1'b0) seen = 8'h01;
    end
    req.strobe_n = 1'b1;
    cmp8(seen, exp);
    for (n = 0; n < 3000 && rdy !== 1'b1; n++) begin
      @(negedge core_clk);
      req.strobe_n = !(again && n >= 20 && n < 24);
    end
    repeat (10) @(negedge core_clk);
    cmp8({7'h00, rdy}, 8'h01);
  endtask

  task automatic enter();
    @(negedge core_clk);
    req.rst = 1'b1;
    req.entry_n = 1'b1;
    repeat (3) @(negedge core_clk);
    req.entry_n = 1'b0;
    repeat (6) @(negedge core_clk);
    cmp8({4'h0, mode, hold, osc, rdy_oe}, 8'h0f);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    close_out();
  end

  initial begin
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    cmp8({4'h0, mode, armed, rdy, dq_oe}, 8'h02);
    $display("reset test done");
    enter();
    strobe(CMD_CHIP_ERASE, 16'h0000, 8'h00, 8'h00, 1'b0);
    put(CMD_IDENTIFY, 16'h0030, 8'h00, 1'b0);
    repeat (ARM - 4) @(negedge core_clk);
    cmp8({7'h00, armed}, 8'h00);
    repeat (10) @(negedge core_clk);
    cmp8({7'h00, armed}, 8'h01);
    $display("arming test done");
    foreach (rows[i]) begin
      if (rows[i].strobed) begin
        strobe(rows[i].cmd, rows[i].addr, rows[i].data, rows[i].exp,
               1'b0);
      end else begin
        rd(rows[i].cmd, rows[i].addr, rows[i].exp);
      end
    end
    $display("command table test done");
    strobe(CMD_BYTE_WRITE, 16'hf010, 8'h00, 8'h00, 1'b0);
    strobe(CMD_LOCK_C, 16'h0000, 8'h00, 8'h01, 1'b0);
    cmp8({3'h0, locks, mapd}, 8'h1f);
    strobe(CMD_CHIP_ERASE, 16'h0000, 8'h00, 8'h01, 1'b1);
    cmp8({3'h0, locks, mapd}, 8'h00);
    $display("lock and busy test done");
    req.ea_n = 1'b0;
    strobe(CMD_LOCK_A, 16'h0000, 8'h00, 8'h00, 1'b0);
    req.ea_n = 1'b1;
    req.entry_n = 1'b1;
    repeat (6) @(negedge core_clk);
    cmp8({6'h00, mode, armed}, 8'h00);
    enter();
    strobe(CMD_LOCK_A, 16'h0000, 8'h00, 8'h00, 1'b0);
    $display("exit and re-entry test done");
    close_out();
  end
endmodule
